/* File: include/psd_pkg.sv */
`default_nettype none
package psd_pkg;

  // ***********************************************************
  // Widths and field layout
  // ***********************************************************
  localparam int M_W      = 7;
  localparam int N_W      = 2;
  localparam int OBS_W    = 3;
  localparam int SR_W     = 14;
  localparam int SR_OBS_H = 13;
  localparam int SR_OBS_L = 11;
  localparam int SR_N_H   = 10;
  localparam int SR_N_L   = 9;
  localparam int SR_M_H   = 6;
  localparam int NCNT_W   = 5;

  // ***********************************************************
  // Codes and reset values
  // ***********************************************************
  localparam logic [N_W-1:0]   N_DIV2   = 2'h0;
  localparam logic [N_W-1:0]   N_DIV4   = 2'h1;
  localparam logic [N_W-1:0]   N_DIV8   = 2'h2;
  localparam logic [N_W-1:0]   N_DIV1   = 2'h3;
  localparam logic [OBS_W-1:0] OBS_SHIFT = 3'h0;
  localparam logic [OBS_W-1:0] OBS_HIGH  = 3'h1;
  localparam logic [OBS_W-1:0] OBS_REF   = 3'h2;
  localparam logic [OBS_W-1:0] OBS_MCNT  = 3'h3;
  localparam logic [OBS_W-1:0] OBS_SYNTH = 3'h4;
  localparam logic [OBS_W-1:0] OBS_LOW   = 3'h5;
  localparam logic [OBS_W-1:0] OBS_BYP   = 3'h6;
  localparam logic [OBS_W-1:0] OBS_QUART = 3'h7;
  localparam logic [M_W-1:0]   M_RST     = 7'h7f;
  localparam logic [N_W-1:0]   N_RST     = 2'h3;

  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int CLK_HZ       = 10000000;
  localparam int LOCK_TIME_MS = 10;
  localparam int LOCK_CYCLES  = LOCK_TIME_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic [OBS_W-1:0] obs;
    logic [N_W-1:0]   nSel;
    logic [M_W-1:0]   mDiv;
  } psd_cfg_t;

  typedef struct packed {
    logic           parLoad_b;
    logic           sClock;
    logic           sData;
    logic           sLoad;
    logic           extRefIn;
    logic           vcoIn;
    logic           pllLocked;
    logic [M_W-1:0] m;
    logic [N_W-1:0] n;
  } psd_pins_t;

endpackage
`default_nettype wire

/* File: hw/psd_synth_cfg.sv */
// Functional notes
// - Reference oscillator is halved before the phase comparator.
// - VCO is divided by the loop divisor and fed to the comparator.
// - Output divider picks one of four ratios with 50% duty.
// - Rising parallel load strobe captures seven M and two N inputs.
// - Parallel path wins over serial path when both set dividers.
// - Fourteen-bit shift register advances on each serial clock rise.
// - Serial latch fall copies shift register while parallel strobe high.
// - Three-bit select from serial stream routes a node to test pin.
// - Lock must be reached within 10 ms of a new configuration.
// - Stream order is select, then N, then nine M bits, MSB first; the code keeps only the low seven (sr[6:0]) as M.
// - N code 00 is /2, 01 is /4, 10 is /8, 11 is /1.
// - Parallel latches are transparent while the strobe is low.
// - Select forced to 000 while strobe low; 110 is PLL bypass.
`default_nettype none
module psd_synth_cfg
  import psd_pkg::*;
#(
  parameter int LOCK_WAIT = LOCK_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Pins from host and analog model
  input  wire psd_pins_t  pins,
  // Divider, observation and lock timeout outputs
  output var  psd_cfg_t   cfgOut,
  output var  logic       refHalf,
  output var  logic       fbOut,
  output var  logic       synthOut,
  output var  logic       testOut,
  output var  logic       lockTimeout
);

  if (LOCK_WAIT < 1 || LOCK_WAIT > 1048575) begin : gChk
    $error("LOCK_WAIT out of range");
  end

  // ***********************************************************
  // Reset release and pin synchronisers
  // ***********************************************************
  logic      rstMeta_b;
  logic      rstSync_b;
  psd_pins_t pinMeta;
  psd_pins_t pin;
  psd_pins_t pinPrev;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  // Pins start at the strobes' idle levels so no false edge appears.
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      pinMeta <= '0;
      pin     <= '0;
      pinPrev <= '0;
    end else begin
      pinMeta <= pins;
      pin     <= pinMeta;
      pinPrev <= pin;
    end
  end

  logic parRise;
  logic sClkRise;
  logic sLoadFall;
  logic refRise;
  logic vcoRise;
  logic bypass;
  logic srcRise;

  assign parRise   = pin.parLoad_b & ~pinPrev.parLoad_b;
  assign sClkRise  = pin.sClock & ~pinPrev.sClock;
  assign sLoadFall = ~pin.sLoad & pinPrev.sLoad;
  assign refRise   = pin.extRefIn & ~pinPrev.extRefIn;
  assign vcoRise   = pin.vcoIn & ~pinPrev.vcoIn;
  assign bypass    = (cfgOut.obs == OBS_BYP);
  // In bypass the serial clock stands in for the VCO at both dividers, except fbOut with mEff 1, which follows the VCO.
  assign srcRise   = bypass ? sClkRise : vcoRise;

  function automatic logic [1:0] nLog(input logic [N_W-1:0] code);
    unique case (code)
      N_DIV2: nLog = 2'h1;
      N_DIV4: nLog = 2'h2;
      N_DIV8: nLog = 2'h3;
      N_DIV1: nLog = 2'h0;
    endcase
  endfunction

  // ***********************************************************
  // Configuration latches and shift register
  // ***********************************************************
  logic [SR_W-1:0] sr;
  logic [SR_W-1:0] next_sr;
  psd_cfg_t        next_cfg;

  always_comb begin
    next_sr  = sr;
    next_cfg = cfgOut;
    if (sClkRise) begin
      next_sr = {sr[SR_W-2:0], pin.sData};
    end
    if (!pin.parLoad_b) begin
      // Transparent while low; the test select is held quiet for jitter.
      next_cfg = '{obs: OBS_SHIFT, nSel: pin.n, mDiv: pin.m};
    end else if (parRise) begin
      next_cfg = '{obs: OBS_SHIFT, nSel: pin.n, mDiv: pin.m};
    end else if (sLoadFall) begin
      next_cfg.obs  = sr[SR_OBS_H:SR_OBS_L];
      next_cfg.nSel = sr[SR_N_H:SR_N_L];
      next_cfg.mDiv = sr[SR_M_H:0];
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      sr     <= '0;
      cfgOut <= '{obs: OBS_SHIFT, nSel: N_RST, mDiv: M_RST};
    end else begin
      sr     <= next_sr;
      cfgOut <= next_cfg;
    end
  end

  // ***********************************************************
  // Dividers, observation mux and lock watch
  // ***********************************************************
  logic [M_W-1:0]    mCnt;
  logic [M_W-1:0]    next_mCnt;
  logic [M_W-1:0]    mEff;
  logic [NCNT_W-1:0] nCnt;
  logic [NCNT_W-1:0] next_nCnt;
  logic [1:0]        nl;
  logic              next_refHalf;
  logic              next_fbOut;
  logic              next_synth;
  logic              next_test;
  logic [19:0]       lockCnt;
  logic [19:0]       next_lockCnt;
  logic              next_lockTo;
  logic              cfgChange;

  assign mEff      = (cfgOut.mDiv == '0) ? 7'h01 : cfgOut.mDiv;
  assign nl        = nLog(cfgOut.nSel);
  assign cfgChange = (next_cfg != cfgOut);

  always_comb begin
    next_refHalf = refRise ? ~refHalf : refHalf;
    next_mCnt    = mCnt;
    next_nCnt    = nCnt;
    if (srcRise) begin
      next_mCnt = (mCnt >= mEff - 7'h01) ? '0 : mCnt + 7'h01;
      next_nCnt = nCnt + 5'h01;
    end
    // Loop divider output is high for the first half of its count.
    next_fbOut = (mCnt < {1'b0, mEff[M_W-1:1]}) ||
                 (mEff == 7'h01 && pin.vcoIn);
    // Counter taps give an exact 50% duty for every even ratio.
    next_synth = (nl == 2'h0) ? (bypass ? pin.sClock : pin.vcoIn)
                              : nCnt[nl - 2'h1];
    unique case (cfgOut.obs)
      OBS_SHIFT: next_test = sr[SR_W-1];
      OBS_HIGH:  next_test = 1'b1;
      OBS_REF:   next_test = refHalf;
      OBS_MCNT:  next_test = fbOut;
      OBS_SYNTH: next_test = synthOut;
      OBS_LOW:   next_test = 1'b0;
      OBS_BYP:   next_test = fbOut;
      OBS_QUART: next_test = nCnt[{1'b0, nl} + 3'h1];
    endcase
    next_lockCnt = lockCnt;
    next_lockTo  = lockTimeout;
    if (cfgChange) begin
      next_lockCnt = '0;
      next_lockTo  = 1'b0;
    end else if (!pin.pllLocked && !lockTimeout) begin
      next_lockCnt = lockCnt + 20'h00001;
      next_lockTo  = (lockCnt == 20'(LOCK_WAIT - 1));
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      refHalf     <= 1'b0;
      mCnt        <= '0;
      nCnt        <= '0;
      fbOut       <= 1'b0;
      synthOut    <= 1'b0;
      testOut     <= 1'b0;
      lockCnt     <= '0;
      lockTimeout <= 1'b0;
    end else begin
      refHalf     <= next_refHalf;
      mCnt        <= next_mCnt;
      nCnt        <= next_nCnt;
      fbOut       <= next_fbOut;
      synthOut    <= next_synth;
      testOut     <= next_test;
      lockCnt     <= next_lockCnt;
      lockTimeout <= next_lockTo;
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_b);

  AST_SHIFT: assert property (
    sClkRise |=> sr == {$past(sr[SR_W-2:0]), $past(pin.sData)})
    else $error("shift register did not advance");
  AST_TRANSP: assert property (
    !pin.parLoad_b |=> cfgOut.mDiv == $past(pin.m) &&
                       cfgOut.nSel == $past(pin.n))
    else $error("parallel latch not transparent");
  AST_OBS_ZERO: assert property (
    !pin.parLoad_b ##1 !pin.parLoad_b |-> cfgOut.obs == OBS_SHIFT)
    else $error("test select not forced low");
  AST_SLOAD: assert property (
    pin.parLoad_b && !parRise && sLoadFall |=>
      cfgOut == {$past(sr[SR_OBS_H:SR_N_L]), $past(sr[SR_M_H:0])})
    else $error("serial latch not committed");
  AST_PLOAD: assert property (
    parRise |=> cfgOut.mDiv == $past(pin.m) && cfgOut.obs == OBS_SHIFT)
    else $error("parallel capture wrong");
  AST_PRIO: assert property (
    !pin.parLoad_b && sLoadFall |=> cfgOut.nSel == $past(pin.n))
    else $error("serial path overrode parallel");
  AST_REF: assert property (
    refRise |=> refHalf != $past(refHalf))
    else $error("reference not halved");
  AST_MDIV: assert property (
    srcRise && mCnt >= mEff - 7'h01 |=> mCnt == '0)
    else $error("loop divider did not wrap");
  AST_NDIV4: assert property (
    srcRise && cfgOut.nSel == N_DIV4 && $stable(cfgOut) &&
    nCnt[1:0] == 2'h1 ##1 cfgOut.nSel == N_DIV4 |=> synthOut)
    else $error("divide by four tap wrong");
  AST_LOCK: assert property (
    $rose(lockTimeout) |-> $past(lockCnt) == 20'(LOCK_WAIT - 1))
    else $error("lock timeout at wrong count");

  COV_PAR:  cover property (parRise);
  COV_SER:  cover property (pin.parLoad_b && sLoadFall);
  COV_BYP:  cover property (bypass && sClkRise);
  COV_LOCK: cover property ($rose(lockTimeout));

endmodule
`default_nettype wire

/* File: sim/psd_host_model.sv */
`default_nettype none
module psd_host_model
  import psd_pkg::*;
(
  // Clock
  input  wire logic      clk,
  // Pins toward the synthesizer
  output var  psd_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // ***********************************************************
  // Host and analog stimulus
  // ***********************************************************
  // The strobe starts low so the board powers up on the pin value.
  initial begin
    pins = '0;
  end

  task automatic wait_clk(input int cnt);
    repeat (cnt) @(negedge clk);
  endtask

  // Lowering the strobe opens the parallel latches.
  task automatic par_open(input logic [M_W-1:0] m, input logic [N_W-1:0] n);
    pins.parLoad_b = 1'b0;
    pins.m         = m;
    pins.n         = n;
    wait_clk(4);
  endtask

  // Inputs stay put around the rise so the capture is clean.
  task automatic par_close();
    pins.parLoad_b = 1'b1;
    wait_clk(4);
  endtask

  // Serial clock period is four system clocks, well under 10 MHz.
  task automatic ser_load(input logic [SR_W-1:0] word);
    for (int i = SR_W - 1; i >= 0; i--) begin
      pins.sData = word[i];
      wait_clk(2);
      pins.sClock = 1'b1;
      wait_clk(2);
      pins.sClock = 1'b0;
    end
    // A released data line must not keep looking valid.
    pins.sData = ~word[0];
    pins.sLoad = 1'b1;
    wait_clk(2);
    pins.sLoad = 1'b0;
    wait_clk(4);
  endtask

  // Slow square waves; sel 0 is the reference, 1 the oscillator.
  task automatic pulses(input int sel, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      if (sel == 0) pins.extRefIn = 1'b1;
      else pins.vcoIn = 1'b1;
      wait_clk(2);
      if (sel == 0) pins.extRefIn = 1'b0;
      else pins.vcoIn = 1'b0;
      wait_clk(2);
    end
    wait_clk(6);
  endtask

  task automatic set_lock(input logic v);
    pins.pllLocked = v;
  endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import psd_pkg::*;

  // ***********************************************************
  // Harness
  // ***********************************************************
  localparam int LOCK_SIM = 20;
  logic      clk;
  logic      rst_b;
  psd_pins_t pins;
  psd_cfg_t  cfgOut;
  logic      refHalf, fbOut, synthOut, testOut, lockTimeout;
  logic      refPrev, fbPrev, synPrev, tstPrev;
  int        failures, comparisons, cycles;
  int        refEdges, fbRises, synRises, tstRises;
  int        expSyn [4] = '{20, 10, 5, 40};

  psd_host_model i_host (.clk(clk), .pins(pins));

  psd_synth_cfg #(.LOCK_WAIT(LOCK_SIM)) i_dut (
    .clk(clk), .rst_b(rst_b), .pins(pins), .cfgOut(cfgOut),
    .refHalf(refHalf), .fbOut(fbOut), .synthOut(synthOut),
    .testOut(testOut), .lockTimeout(lockTimeout));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim();
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The run needs about 1130 cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles++;
    if (refHalf !== refPrev) refEdges++;
    if (fbOut === 1'b1 && fbPrev === 1'b0) fbRises++;
    if (synthOut === 1'b1 && synPrev === 1'b0) synRises++;
    if (testOut === 1'b1 && tstPrev === 1'b0) tstRises++;
    refPrev = refHalf;
    fbPrev  = fbOut;
    synPrev = synthOut;
    tstPrev = testOut;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ***********************************************************
  // Tests
  // ***********************************************************
  initial begin
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    chk("cfgOut", {OBS_SHIFT, N_RST, M_RST}, cfgOut);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    i_host.par_open(7'h30, N_DIV2);
    chk("cfgOut", {OBS_SHIFT, N_DIV2, 7'h30}, cfgOut);
    i_host.par_open(7'h19, N_DIV8);
    chk("cfgOut", {OBS_SHIFT, N_DIV8, 7'h19}, cfgOut);
    i_host.ser_load({OBS_HIGH, N_DIV1, 9'h185});
    chk("cfgOut", {OBS_SHIFT, N_DIV8, 7'h19}, cfgOut);
    i_host.par_close();
    chk("cfgOut", {OBS_SHIFT, N_DIV8, 7'h19}, cfgOut);
    i_host.ser_load({OBS_HIGH, N_DIV1, 9'h185});
    chk("cfgOut", {OBS_HIGH, N_DIV1, 7'h05}, cfgOut);
    chk("testOut", 16'h1, testOut);
    i_host.ser_load({OBS_LOW, N_DIV4, 9'h02a});
    chk("cfgOut", {OBS_LOW, N_DIV4, 7'h2a}, cfgOut);
    chk("testOut", 16'h0, testOut);
    refEdges = 0;
    i_host.pulses(0, 8);
    chk("refEdges", 16'h8, refEdges);
    for (int k = 0; k < 4; k++) begin
      i_host.par_open(7'h05, k[1:0]);
      chk("obs", OBS_SHIFT, cfgOut.obs);
      i_host.par_close();
      fbRises  = 0;
      synRises = 0;
      i_host.pulses(1, 40);
      chk("fbRises", 16'h8, fbRises);
      chk("synRises", expSyn[k], synRises);
    end
    repeat (30) @(negedge clk);
    chk("lockTimeout", 16'h1, lockTimeout);
    i_host.set_lock(1'b1);
    i_host.par_open(7'h20, N_DIV2);
    i_host.par_close();
    repeat (30) @(negedge clk);
    chk("lockTimeout", 16'h0, lockTimeout);
    // Bypass: the serial clock alone now drives both dividers.
    i_host.ser_load({OBS_BYP, N_DIV2, 9'h004});
    fbRises  = 0;
    synRises = 0;
    tstRises = 0;
    i_host.ser_load({OBS_BYP, N_DIV2, 9'h004});
    chk("fbRises", 16'h3, fbRises);
    chk("synRises", 16'h7, synRises);
    chk("tstRises", 16'h3, tstRises);
    end_sim();
  end

  initial begin
    failures    = 0;
    comparisons = 0;
    cycles      = 0;
    refPrev     = 1'b0;
    fbPrev      = 1'b0;
    synPrev     = 1'b0;
    tstPrev     = 1'b0;
  end
endmodule
`default_nettype wire
